// ### hw/pwr_seq_pkg.sv
// constants for the power monitor conversion sequencer
// assumes a 40 MHz aclk and an AXI4-Lite register bus with 32-bit data
package pwr_seq_pkg;
  // register byte offsets
  localparam logic [7:0] ADC_CFG_OFS   = 8'h00;  // mode, inputs, conversion times, averaging
  localparam logic [7:0] DEV_CFG_OFS   = 8'h04;  // conversion delay
  localparam logic [7:0] CAL_OFS       = 8'h08;  // shunt calibration
  localparam logic [7:0] DIAG_OFS      = 8'h0C;  // diagnostic_alert_register
  localparam logic [7:0] SHUNT_OFS     = 8'h10;
  localparam logic [7:0] BUS_OFS       = 8'h14;
  localparam logic [7:0] TEMP_OFS      = 8'h18;
  localparam logic [7:0] CURR_OFS      = 8'h1C;
  localparam logic [7:0] POWER_OFS     = 8'h20;
  localparam logic [7:0] SAMPLE_IN_OFS = 8'h24;  // converter sample from the front end
  // adc configuration fields
  localparam int MODE_LSB = 0;   // [2:0] mode: bit0 shunt, bit1 bus, bit2 temp enable
  localparam int CONT_BIT = 3;   // 1 continuous, 0 triggered
  localparam int CTS_LSB  = 4;   // [6:4] shunt conversion time code
  localparam int CTB_LSB  = 7;   // [9:7] bus conversion time code
  localparam int CTT_LSB  = 10;  // [12:10] temperature conversion time code
  localparam int AVG_LSB  = 13;  // [16:13] averaging code, 2**code samples, 0..10
  localparam int DLY_LSB  = 0;   // conversion_delay [7:0] in 2 ms steps
  localparam int CONVERSION_READY_ALERT_ENABLE_BIT = 8;   // conversion_ready_alert_enable in diag register
  localparam int CONVERSION_READY_FLAG_BIT = 1;  // conversion_ready_flag in diag register
  localparam logic [3:0] AVG_MAX_CODE = 4'hA;  // 1024 samples
  // reset values
  localparam logic [16:0] ADC_CFG_RST = 17'h00FFF;
  localparam logic [7:0]  DLY_RST     = 8'h00;
  // timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int CT_MIN_US    = 50;     // shortest conversion
  localparam int CT_MAX_US    = 4120;   // longest conversion
  localparam int DLY_STEP_MS  = 2;
  localparam int CT_MIN_CYC   = CT_MIN_US * (CLK_HZ / 1_000_000);
  localparam int DLY_STEP_CYC = DLY_STEP_MS * (CLK_HZ / 1000);
  // conversion time codes in microseconds
  localparam int CT_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
endpackage

// ### hw/pwr_seq.sv
// power monitor conversion sequencer with an AXI4-Lite register slave
// assumes a single aclk domain; the converter result comes in as the sample register
// Operation
// R1: one multiplexer feeds one shared converter
// R2: current then power from latest bus
// R3: zero calibration gives zero power
// R4: averaging accumulates, loads outputs at end
// R5: math runs beside conversions, no added time
// R6: shunt samples are signed
// R7: any combination of inputs selectable
// R8: no averaging, each result updates immediately
// R9: per input conversion time 50us to 4.12ms
// R10: enabled inputs converted back to back
// R11: averaging repeats whole sequence then updates
// R12: results hold; reads never disturb conversion
// R13: continuous mode loops forever
// R14: triggered runs once then shutdown
// R15: mode write aborts and restarts
// R16: ready flag only after full sequence
// R17: ready clears on config write, diag read
// R18: start delay 0 to 510ms, 2ms steps
// R19: one averaging count for all inputs
// R20: alert on completion when enabled
// R21: delay timed from starting write
// R22: shutdown keeps results and flag
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module pwr_seq (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // converter front end
  output logic [1:0]       mux_sel,
  output logic             conv_busy,
  output logic             alert
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_CONV  = 4'b0100,
    ST_DONE  = 4'b1000
  } state_t;

  state_t       st_q, st_d;
  logic [16:0]  cfg_q;
  logic [7:0]   dly_q;
  logic [15:0]  cal_q;
  logic         conversion_ready_alert_enable_en_q;
  logic         ready_q;
  logic [15:0]  sample_q;
  logic signed [15:0] shunt_q, bus_q, temp_q;
  logic signed [31:0] curr_q, power_q;
  logic signed [31:0] curr_last_q;
  logic signed [41:0] acc_shunt_q, acc_bus_q, acc_temp_q, acc_curr_q, acc_pow_q;
  logic [1:0]   ch_q;
  // 25 bits: the longest start delay is about 20.4M cycles, past 2**24
  logic [24:0]  cnt_q;
  logic [10:0]  avg_n_q;
  logic         aw_q, w_q;
  logic [7:0]   awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         alert_q;

  // write channel: address and data latched in either order
  wire       aw_hs    = s_axi_awvalid && s_axi_awready;
  wire       w_hs     = s_axi_wvalid && s_axi_wready;
  wire       wr_go    = aw_q && w_q && !s_axi_bvalid;
  wire       wr_cfg   = wr_go && awaddr_q == pwr_seq_pkg::ADC_CFG_OFS && wstrb_q[0];
  wire       wr_dly   = wr_go && awaddr_q == pwr_seq_pkg::DEV_CFG_OFS && wstrb_q[0];
  wire       wr_cal   = wr_go && awaddr_q == pwr_seq_pkg::CAL_OFS && wstrb_q[0];
  wire       wr_diag  = wr_go && awaddr_q == pwr_seq_pkg::DIAG_OFS && wstrb_q[1];
  wire       wr_samp  = wr_go && awaddr_q == pwr_seq_pkg::SAMPLE_IN_OFS && wstrb_q[0];
  wire       wr_known = wr_cfg || wr_dly || wr_cal || wr_diag || wr_samp;
  wire [16:0] new_cfg = wdata_q[16:0];
  wire       new_shut = new_cfg[2:0] == 3'h0;
  wire       ar_hs    = s_axi_arvalid && s_axi_arready;
  wire       rd_diag  = ar_hs && s_axi_araddr == pwr_seq_pkg::DIAG_OFS;

  // sequencing decodes
  wire [2:0] en_mask  = cfg_q[pwr_seq_pkg::MODE_LSB +: 3];
  wire [3:0] avg_code = (cfg_q[pwr_seq_pkg::AVG_LSB +: 4] > pwr_seq_pkg::AVG_MAX_CODE) ?
                        pwr_seq_pkg::AVG_MAX_CODE : cfg_q[pwr_seq_pkg::AVG_LSB +: 4];
  wire [10:0] avg_tot = 11'h001 << avg_code;  // see R19
  wire [2:0] ct_code  = (ch_q == 2'h0) ? cfg_q[pwr_seq_pkg::CTS_LSB +: 3] :
                        (ch_q == 2'h1) ? cfg_q[pwr_seq_pkg::CTB_LSB +: 3] :
                                         cfg_q[pwr_seq_pkg::CTT_LSB +: 3];
  wire [24:0] ct_cyc  = 25'(pwr_seq_pkg::CT_US[ct_code] * (pwr_seq_pkg::CLK_HZ / 1_000_000));
  wire [24:0] dly_cyc = 25'(dly_q) * 25'(pwr_seq_pkg::DLY_STEP_CYC);  // see R18
  wire       conv_end = st_q == ST_CONV && cnt_q == 25'h0000001;
  // first enabled channel, and next enabled channel after the current one, in shunt, bus, temp order
  wire [1:0] first_ch = en_mask[0] ? 2'h0 : en_mask[1] ? 2'h1 : 2'h2;  // see R7
  wire       has_next = (ch_q == 2'h0 && en_mask[2:1] != 2'h0) || (ch_q == 2'h1 && en_mask[2]);
  wire [1:0] next_ch  = (ch_q == 2'h0 && en_mask[1]) ? 2'h1 : 2'h2;
  wire       last_avg = avg_n_q + 11'h001 == avg_tot;
  wire       seq_end  = conv_end && !has_next;
  wire       avg_on   = avg_code != 4'h0;

  // background math on the just finished sample; the shunt is signed
  wire signed [15:0] samp_s  = signed'(sample_q);  // see R6
  wire signed [31:0] curr_nw = 32'(samp_s * signed'({1'b0, cal_q}));
  wire signed [31:0] pow_nw  = (cal_q == 16'h0000) ? 32'sh0 :
                               32'((curr_last_q >>> 16) * samp_s);  // see R2 see R3

  // sequencer state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  st_d = st_q;
      ST_DELAY: if (cnt_q == 25'h0000000) st_d = ST_CONV;
      ST_CONV:  if (seq_end && last_avg) st_d = ST_DONE;
      ST_DONE:  st_d = cfg_q[pwr_seq_pkg::CONT_BIT] ? ST_CONV : ST_IDLE;  // see R13 see R14
      default:  st_d = ST_IDLE;
    endcase
    if (wr_cfg) st_d = new_shut ? ST_IDLE : ST_DELAY;  // see R15 see R21
  end

  // state, counters and channel pointer; one converter, one channel at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 25'h0000000;
      ch_q    <= 2'h0;
      avg_n_q <= 11'h000;
    end else begin
      st_q <= st_d;
      // the delay counts from the starting write itself
      if (wr_cfg) begin
        cnt_q   <= dly_cyc;  // see R21
        avg_n_q <= 11'h000;
      end else if (st_q == ST_DELAY && cnt_q == 25'h0000000) begin
        ch_q  <= first_ch;
        cnt_q <= 25'h0000000;
      end else if (st_q == ST_DELAY) begin
        cnt_q <= cnt_q - 25'h0000001;
      end else if (st_q == ST_CONV && cnt_q == 25'h0000000) begin
        cnt_q <= ct_cyc;  // see R9
      end else if (conv_end) begin
        // zero here makes the next channel reload its own time
        cnt_q <= 25'h0000000;
        if (has_next) ch_q <= next_ch;  // see R10
        else begin
          ch_q    <= first_ch;  // see R11
          avg_n_q <= last_avg ? 11'h000 : avg_n_q + 11'h001;
        end
      end else if (st_q == ST_CONV) begin
        cnt_q <= cnt_q - 25'h0000001;
      end else if (st_q == ST_DONE) begin
        cnt_q <= 25'h0000000;
        ch_q  <= first_ch;
      end
    end
  end

  // accumulation and result loading; results hold through idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shunt_q <= 16'sh0; bus_q <= 16'sh0; temp_q <= 16'sh0;
      curr_q <= 32'sh0; power_q <= 32'sh0; curr_last_q <= 32'sh0;
      acc_shunt_q <= 42'sh0; acc_bus_q <= 42'sh0; acc_temp_q <= 42'sh0;
      acc_curr_q <= 42'sh0; acc_pow_q <= 42'sh0;
    end else if (wr_cfg) begin
      acc_shunt_q <= 42'sh0; acc_bus_q <= 42'sh0; acc_temp_q <= 42'sh0;
      acc_curr_q <= 42'sh0; acc_pow_q <= 42'sh0;
    end else if (conv_end) begin  // see R1 see R5 see R12
      if (ch_q == 2'h0) begin
        curr_last_q <= curr_nw;
        if (!avg_on) begin
          shunt_q <= samp_s;  // see R8
          curr_q  <= curr_nw;
        end else if (last_avg) begin
          shunt_q <= 16'((acc_shunt_q + 42'(samp_s)) >>> avg_code);  // see R4
          curr_q  <= 32'((acc_curr_q + 42'(curr_nw)) >>> avg_code);
          acc_shunt_q <= 42'sh0;
          acc_curr_q  <= 42'sh0;
        end else begin
          acc_shunt_q <= acc_shunt_q + 42'(samp_s);
          acc_curr_q  <= acc_curr_q + 42'(curr_nw);
        end
      end else if (ch_q == 2'h1) begin
        if (!avg_on) begin
          bus_q   <= samp_s;
          power_q <= pow_nw;
        end else if (last_avg) begin
          bus_q   <= 16'((acc_bus_q + 42'(samp_s)) >>> avg_code);
          power_q <= 32'((acc_pow_q + 42'(pow_nw)) >>> avg_code);
          acc_bus_q <= 42'sh0;
          acc_pow_q <= 42'sh0;
        end else begin
          acc_bus_q <= acc_bus_q + 42'(samp_s);
          acc_pow_q <= acc_pow_q + 42'(pow_nw);
        end
      end else begin
        if (!avg_on) temp_q <= samp_s;
        else if (last_avg) begin
          temp_q     <= 16'((acc_temp_q + 42'(samp_s)) >>> avg_code);
          acc_temp_q <= 42'sh0;
        end else acc_temp_q <= acc_temp_q + 42'(samp_s);
      end
    end
  end

  // config registers and ready flag; a completing sequence beats a clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= pwr_seq_pkg::ADC_CFG_RST;
      dly_q     <= pwr_seq_pkg::DLY_RST;  // see R18
      cal_q     <= 16'h0000;
      conversion_ready_alert_enable_en_q <= 1'b0;
      sample_q  <= 16'h0000;
      ready_q   <= 1'b0;
      alert_q   <= 1'b0;
    end else begin
      if (wr_cfg) cfg_q <= new_cfg;
      if (wr_dly) dly_q <= wdata_q[pwr_seq_pkg::DLY_LSB +: 8];
      if (wr_cal) cal_q <= wdata_q[15:0];
      if (wr_diag) conversion_ready_alert_enable_en_q <= wdata_q[pwr_seq_pkg::CONVERSION_READY_ALERT_ENABLE_BIT];
      if (wr_samp) sample_q <= wdata_q[15:0];
      if (st_q == ST_DONE) ready_q <= 1'b1;  // see R16
      else if ((wr_cfg && !new_shut) || rd_diag) ready_q <= 1'b0;  // see R17 see R22
      alert_q <= (st_q == ST_DONE && conversion_ready_alert_enable_en_q) ? 1'b1 : (rd_diag ? 1'b0 : alert_q);  // see R20
    end
  end

  // axi write handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= 8'h00; wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0; s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
    end else begin
      if (aw_hs) begin aw_q <= 1'b1; awaddr_q <= s_axi_awaddr; end
      if (w_hs) begin w_q <= 1'b1; wdata_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb; end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known || awaddr_q <= pwr_seq_pkg::SAMPLE_IN_OFS ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // read mux
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      pwr_seq_pkg::ADC_CFG_OFS: rd_mux = {15'h0000, cfg_q};
      pwr_seq_pkg::DEV_CFG_OFS: rd_mux = {24'h000000, dly_q};
      pwr_seq_pkg::CAL_OFS:     rd_mux = {16'h0000, cal_q};
      pwr_seq_pkg::DIAG_OFS:    rd_mux = {23'h000000, conversion_ready_alert_enable_en_q, 6'h00, ready_q, 1'b0};
      pwr_seq_pkg::SHUNT_OFS:   rd_mux = 32'(shunt_q);
      pwr_seq_pkg::BUS_OFS:     rd_mux = 32'(bus_q);
      pwr_seq_pkg::TEMP_OFS:    rd_mux = 32'(temp_q);
      pwr_seq_pkg::CURR_OFS:    rd_mux = curr_q;
      pwr_seq_pkg::POWER_OFS:   rd_mux = power_q;
      pwr_seq_pkg::SAMPLE_IN_OFS: rd_mux = {16'h0000, sample_q};
      default: begin rd_mux = 32'h00000000; rd_ok = 1'b0; end
    endcase
  end

  // axi read and front-end outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h00000000; s_axi_rresp <= 2'h0;
      mux_sel <= 2'h0; conv_busy <= 1'b0;
    end else begin
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      mux_sel   <= ch_q;
      conv_busy <= st_q == ST_CONV;
    end
  end

  assign s_axi_awready = !aw_q && aresetn;
  assign s_axi_wready  = !w_q && aresetn;
  assign s_axi_arready = !s_axi_rvalid && aresetn;
  assign alert         = alert_q;

  // checks
  ready_only_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ready_q) |-> $past(st_q) == ST_DONE) else $error("ready set outside done");  // see R16
  ready_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_diag && st_q != ST_DONE |=> !ready_q) else $error("ready not cleared by read");  // see R17
  mode_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg && !new_shut |=> st_q == ST_DELAY) else $error("mode write did not restart");  // see R15
  shut_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg && new_shut |=> st_q == ST_IDLE) else $error("shutdown write not idle");  // see R15
  trig_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_DONE && !cfg_q[pwr_seq_pkg::CONT_BIT] && !wr_cfg |=> st_q == ST_IDLE)
    else $error("triggered run did not stop");  // see R14
  cont_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_DONE && cfg_q[pwr_seq_pkg::CONT_BIT] && !wr_cfg |=> st_q == ST_CONV)
    else $error("continuous run stopped");  // see R13
  idle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_IDLE && !wr_cfg |=> $stable(shunt_q) && $stable(power_q))
    else $error("results changed in shutdown");  // see R22
  zero_cal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_q == 16'h0000 && conv_end && ch_q == 2'h1 && !avg_on |=> power_q == 32'sh0)
    else $error("power nonzero with zero calibration");  // see R3
  alert_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_DONE && conversion_ready_alert_enable_en_q |=> alert_q) else $error("alert missing");  // see R20
  cov_trig_c: cover property (@(posedge aclk) st_q == ST_DONE && !cfg_q[pwr_seq_pkg::CONT_BIT]);
  cov_avg_c: cover property (@(posedge aclk) seq_end && last_avg && avg_on);
  cov_abort_c: cover property (@(posedge aclk) st_q == ST_CONV && wr_cfg);

  // only three channels exist; code 3 would put no input on the converter
  one_chan_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R1
    conv_busy |-> mux_sel != 2'h3)
    else $error("converter on no valid channel");

  // the busy output follows the converting state one cycle late
  busy_conv_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R10
    st_q == ST_CONV |=> conv_busy)
    else $error("busy missing while converting");

  // the delay runs to zero before any conversion starts
  delay_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R21
    st_q == ST_DELAY && cnt_q != 25'h0000000 && !wr_cfg |=> st_q == ST_DELAY)
    else $error("delay cut short");

  // a starting write loads the programmed delay into the counter
  dly_load_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R18
    wr_cfg && !new_shut |=> cnt_q == $past(dly_cyc))
    else $error("delay not loaded");

  // mid-average samples only feed the accumulators and curr_last_q
  avg_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R4
    conv_end && avg_on && !last_avg |=> $stable(shunt_q) && $stable(bus_q) && $stable(temp_q))
    else $error("result moved before averaging ended");

  // without averaging the shunt result takes the sample at once
  no_avg_upd_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see R8
    conv_end && ch_q == 2'h0 && !avg_on && !wr_cfg |=> shunt_q == $past(samp_s))
    else $error("shunt result not updated");

  // scenarios worth seeing: a continuous loop and a real start delay
  cov_cont_c: cover property (@(posedge aclk) st_q == ST_DONE && cfg_q[pwr_seq_pkg::CONT_BIT]);
  cov_delay_c: cover property (@(posedge aclk) st_q == ST_DELAY && cnt_q != 25'h0000000);
endmodule // pwr_seq

// ### tb/axil_host.sv
// axi4-lite host model that drives the register slave of the sequencer
// assumes one aclk domain and that the bench calls one task at a time
`timescale 1ns/10ps
module axil_host (
  // clock
  input  wire logic        aclk,
  // write address, data and response
  output logic             awvalid,
  input  wire logic        awready,
  output logic [7:0]       awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // read address and data
  output logic             arvalid,
  input  wire logic        arready,
  output logic [7:0]       araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  // quiet bus from time zero so nothing is taken during reset
  initial begin
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
  end

  // address and data offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // rready held from the start; the data is taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule // axil_host

// ### tb/power_monitor_conversion_sequencer_test.sv
// self-checking bench for the power monitor conversion sequencer
// assumes axil_host for bus cycles; the sample register stands in for the converter
`timescale 1ns/10ps
`define check(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module power_monitor_conversion_sequencer_test;
  localparam logic [7:0] CFG  = pwr_seq_pkg::ADC_CFG_OFS;
  localparam logic [7:0] DIAG = pwr_seq_pkg::DIAG_OFS;
  localparam logic [7:0] SMP  = pwr_seq_pkg::SAMPLE_IN_OFS;
  // clock, reset, bus and front end wires
  logic        aclk, aresetn, conv_busy, alert;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, mux_sel;
  int          n_mismatch, samples_checked, cyc[3], first[3];

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  pwr_seq dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .mux_sel(mux_sel), .conv_busy(conv_busy), .alert(alert));
  axil_host host_u (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  // conversion time of a code in clock cycles
  function automatic int ct(input int k);
    return pwr_seq_pkg::CT_US[k] * (pwr_seq_pkg::CLK_HZ / 1_000_000);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.wr(a, d, resp);
    `check("write_resp", 2'b00, resp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, rd_d, resp);
    `check($sformatf("reg_%0h", a), e, rd_d)
  endtask
  task automatic ch_time(input int ch, input int e);
    `check("chan_cycles", 1'b1, cyc[ch] >= e - 5 && cyc[ch] <= e + 20)
  endtask
  // waits for the completion alert, tallying busy cycles per channel
  task automatic wait_done(input int total);
    int n;
    n = 0;
    cyc = '{0, 0, 0};
    first = '{0, 0, 0};
    while (alert !== 1'b1 && n < total + 300) begin
      @(posedge aclk);
      n++;
      if (conv_busy === 1'b1 && mux_sel < 2'd3) begin
        cyc[mux_sel]++;
        if (first[mux_sel] == 0) first[mux_sel] = n;
      end
    end
    `check("done_time", 1'b1, n >= total - 20 && n < total + 300)
    rd(DIAG, 32'h0000_0102);
    @(posedge aclk);
    `check("alert_cleared", 1'b0, alert)
  endtask

  task automatic t_reset;
    `check("idle_outputs", 2'b00, {conv_busy, alert})
    rd(CFG, {15'h0000, pwr_seq_pkg::ADC_CFG_RST});
    rd(pwr_seq_pkg::DEV_CFG_OFS, 32'h0000_0000);
    wr(pwr_seq_pkg::DEV_CFG_OFS, 32'h0000_00FF);
    rd(pwr_seq_pkg::DEV_CFG_OFS, 32'h0000_00FF);
    wr(pwr_seq_pkg::DEV_CFG_OFS, 32'h0000_0000);
    host_u.rd(8'h28, rd_d, resp);
    `check("unmapped_read", 34'h2_0000_0000, {resp, rd_d})
    host_u.wr(8'h28, 32'h0000_0000, resp);
    `check("unmapped_write", 2'b10, resp)
  endtask
  // single shot, shunt only, negative sample, then shutdown
  task automatic t_single;
    int n;
    n = 0;
    wr(DIAG, 32'h0000_0100);
    wr(pwr_seq_pkg::CAL_OFS, 32'h0000_8000);
    wr(SMP, 32'h0000_FFFC);
    wr(CFG, 32'h0000_0001);
    wait_done(ct(0));
    ch_time(0, ct(0));
    `check("other_chans", 0, cyc[1] + cyc[2])
    rd(pwr_seq_pkg::SHUNT_OFS, 32'hFFFF_FFFC);
    rd(pwr_seq_pkg::CURR_OFS, 32'hFFFE_0000);
    repeat (3000) begin
      @(posedge aclk);
      n += int'(conv_busy === 1'b1 || alert === 1'b1);
    end
    `check("shutdown_idle", 0, n)
    rd(pwr_seq_pkg::SHUNT_OFS, 32'hFFFF_FFFC);
    rd(DIAG, 32'h0000_0100);
  endtask
  // shunt and bus: current then power, zero calibration gives zero power
  task automatic t_power;
    wr(SMP, 32'h0000_0004);
    wr(CFG, 32'h0000_0003);
    wait_done(2 * ct(0));
    `check("shunt_first", 1'b1, first[0] < first[1])
    rd(pwr_seq_pkg::BUS_OFS, 32'h0000_0004);
    rd(pwr_seq_pkg::CURR_OFS, 32'h0002_0000);
    rd(pwr_seq_pkg::POWER_OFS, 32'h0000_0008);
    wr(pwr_seq_pkg::CAL_OFS, 32'h0000_0000);
    wr(CFG, 32'h0000_0003);
    wait_done(2 * ct(0));
    rd(pwr_seq_pkg::POWER_OFS, 32'h0000_0000);
  endtask
  // two averages over shunt and bus; results hold until the end
  task automatic t_avg;
    wr(pwr_seq_pkg::CAL_OFS, 32'h0000_8000);
    wr(SMP, 32'h0000_0006);
    wr(CFG, 32'h0000_2003);
    repeat (3000) @(posedge aclk);
    rd(pwr_seq_pkg::SHUNT_OFS, 32'h0000_0004);
    wait_done(4 * ct(0) - 3010);
    rd(pwr_seq_pkg::SHUNT_OFS, 32'h0000_0006);
    rd(pwr_seq_pkg::CURR_OFS, 32'h0003_0000);
    rd(pwr_seq_pkg::POWER_OFS, 32'h0000_0012);
  endtask
  // all three inputs, bus with a longer conversion time
  task automatic t_all;
    wr(CFG, 32'h0000_0087);
    wait_done(2 * ct(0) + ct(1));
    ch_time(1, ct(1));
    ch_time(2, ct(0));
    `check("chan_order", 1'b1, first[0] < first[1] && first[1] < first[2])
    rd(pwr_seq_pkg::TEMP_OFS, 32'h0000_0006);
  endtask
  // continuous loop, abort by mode write, flag clearing on config writes
  task automatic t_cont;
    wr(CFG, 32'h0000_0009);
    wait_done(ct(0));
    wait_done(ct(0));
    repeat (1000) @(posedge aclk);
    wr(CFG, 32'h0000_0001);
    wait_done(ct(0));
    wr(CFG, 32'h0000_0001);
    repeat (ct(0) + 300) @(posedge aclk);
    wr(CFG, 32'h0000_0000);
    rd(DIAG, 32'h0000_0102);
    wr(CFG, 32'h0000_0001);
    repeat (ct(0) + 300) @(posedge aclk);
    wr(CFG, 32'h0000_0001);
    rd(DIAG, 32'h0000_0100);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_single;
    t_power;
    t_avg;
    t_all;
    t_cont;
    end_of_test;
  end
  // about 40k cycles of traffic; a hang past this counts as a mismatch
  initial begin
    repeat (90_000) @(posedge aclk);
    n_mismatch++;
    end_of_test;
  end
endmodule // power_monitor_conversion_sequencer_test
